// >>> logic/arf_result_formatter.sv
// Result formatting and temperature sensor routing for the 10-bit converter
`timescale 1ns/100ps
// Overview of operation
// - The finished code is readable in the two result bytes once the done flag is raised.
// - Single-ended results are the unsigned code vin*1024/vref from 0x000 to 0x3ff.
// - Unipolar differential results are the unsigned code diff*1024*gain/vref.
// - Unipolar differential results saturate to zero when the negative input is higher.
// - Unipolar mode is the reset mode; bipolar applies only while bipolar select is one.
// - Bipolar results are diff*512*gain/vref in two's complement from 0x200 to 0x1ff.
// - In bipolar mode the top result bit is the sign, one meaning negative.
// - Channel code 1111 routes and enables the on-chip temperature sensor.
// - Left adjust set shows the result left-justified, otherwise right-justified.
module arf_result_formatter
  import arf_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Control bits
  input  wire logic        bipolar_select,
  input  wire logic        left_adjust_select,
  input  wire logic [3:0]  channel_select,
  input  wire logic        channel_is_diff,
  input  wire logic        done_flag_clear,
  // Conversion core
  input  wire logic        core_done,
  input  wire logic [10:0] core_raw_diff,
  // Result and status
  output logic [7:0]       result_low_byte,
  output logic [7:0]       result_high_byte,
  output logic             conversion_done_flag,
  output logic             result_sign_bit,
  output logic             temp_sensor_enable,
  output logic             temp_sensor_channel
);
  arf_mode_e   mode;
  logic [9:0]  shaped;
  logic [9:0]  result_r;
  logic        bipolar_r;
  logic [15:0] packed_nxt;

  // Bipolar only ever applies to differential pairs
  always_comb begin
    if (!channel_is_diff) begin
      mode = ARF_SINGLE;
    end else if (bipolar_select) begin
      mode = ARF_BIPOL;
    end else begin
      mode = ARF_UNIPOL;
    end
  end

  arf_code_shaper u_shaper (
    .mode     (mode),
    .raw_diff (core_raw_diff),
    .code     (shaped)
  );

  // Latched only on completion so both bytes always belong to one code
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      result_r  <= ARF_RES_RST;
      bipolar_r <= 1'b0;
    end else if (clk_en && core_done) begin
      result_r  <= shaped;
      bipolar_r <= (mode == ARF_BIPOL);
    end
  end

  // Done flag: a new completion wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conversion_done_flag <= 1'b0;
    end else if (clk_en) begin
      if (core_done) begin
        conversion_done_flag <= 1'b1;
      end else if (done_flag_clear) begin
        conversion_done_flag <= 1'b0;
      end
    end
  end

  // Adjust acts on the stored code at the next enabled clock, even mid-conversion
  always_comb begin
    packed_nxt = 16'h0000;
    if (core_done) begin
      packed_nxt = left_adjust_select ? {shaped, 6'h00} : {6'h00, shaped};
    end else begin
      packed_nxt = left_adjust_select ? {result_r, 6'h00} : {6'h00, result_r};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      result_low_byte  <= ARF_BYTE_RST;
      result_high_byte <= ARF_BYTE_RST;
      result_sign_bit  <= 1'b0;
    end else if (clk_en) begin
      result_low_byte  <= packed_nxt[7:0];
      result_high_byte <= packed_nxt[15:8];
      result_sign_bit  <= core_done ? (mode == ARF_BIPOL) & shaped[ARF_SIGN_POS]
                                    : bipolar_r & result_r[ARF_SIGN_POS];
    end
  end

  // Temperature sensor routing
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      temp_sensor_enable  <= 1'b0;
      temp_sensor_channel <= 1'b0;
    end else if (clk_en) begin
      temp_sensor_enable  <= (channel_select == ARF_CH_TEMP);
      temp_sensor_channel <= (channel_select == ARF_CH_TEMP);
    end
  end
endmodule : arf_result_formatter

// >>> logic/arf_pkg.sv
// Constants shared by the result formatter
package arf_pkg;
  localparam int          ARF_RES_W        = 10;
  localparam int          ARF_CH_W         = 4;
  localparam logic [3:0]  ARF_CH_TEMP      = 4'hf;
  localparam logic [9:0]  ARF_CODE_MIN     = 10'h000;
  localparam logic [9:0]  ARF_CODE_MAX     = 10'h3ff;
  localparam logic [9:0]  ARF_BIP_MIN      = 10'h200;
  localparam logic [9:0]  ARF_BIP_MAX      = 10'h1ff;
  localparam int          ARF_SIGN_POS     = 9;
  localparam int          ARF_LEFT_SHIFT   = 6;
  localparam logic [7:0]  ARF_BYTE_RST     = 8'h00;
  localparam logic [9:0]  ARF_RES_RST      = 10'h000;
  typedef enum logic [2:0] {
    ARF_SINGLE  = 3'b001,
    ARF_UNIPOL  = 3'b010,
    ARF_BIPOL   = 3'b100
  } arf_mode_e;
endpackage : arf_pkg

// >>> logic/arf_code_shaper.sv
// Converts a signed raw difference into the code for the selected conversion form
`timescale 1ns/100ps
module arf_code_shaper
  import arf_pkg::*;
(
  // Mode
  input  wire arf_mode_e   mode,
  // Raw sample from the core, signed, 11 bits
  input  wire logic [10:0] raw_diff,
  // Shaped code
  output logic [9:0]       code
);
  always_comb begin
    case (mode)
      ARF_SINGLE: begin
        code = raw_diff[10] ? ARF_CODE_MIN : raw_diff[9:0];
      end
      ARF_UNIPOL: begin
        code = raw_diff[10] ? ARF_CODE_MIN : raw_diff[9:0];
      end
      ARF_BIPOL: begin
        // Halving the 11-bit signed raw value always lands inside 0x200..0x1ff, so no clamp
        code = raw_diff[10:1];
      end
      default: begin
        code = ARF_CODE_MIN;
      end
    endcase
  end
endmodule : arf_code_shaper

// >>> dv/arf_core_model.sv
// Conversion core stand-in for the formatter
`timescale 1ns/100ps
module arf_core_model (
  input wire logic core_clk, start,
  input wire logic [10:0] sample,
  output logic core_done,
  output logic [10:0] core_raw_diff
);
  // Inverted outside the done cycle, so stale data never passes
  always @(posedge core_clk) {core_done, core_raw_diff} <= {start, start ? sample : ~sample};
endmodule : arf_core_model

// >>> dv/arf_result_formatter_sva.sv
// Port assertions for the result formatter
`timescale 1ns/100ps
module arf_result_formatter_sva
  import arf_pkg::*;
(
  input wire logic core_clk, rst_n, clk_en, bipolar_select, left_adjust_select,
  input wire logic [3:0] channel_select,
  input wire logic channel_is_diff, done_flag_clear, core_done,
  input wire logic [10:0] core_raw_diff,
  input wire logic [7:0] result_low_byte, result_high_byte,
  input wire logic conversion_done_flag, result_sign_bit, temp_sensor_enable,
  input wire logic temp_sensor_channel
);
  wire tk = core_done && clk_en;
  wire ok = clk_en && !core_done;
  wire bp = channel_is_diff && bipolar_select;
  wire tmp = channel_select == ARF_CH_TEMP;
  wire [15:0] res = {result_high_byte, result_low_byte};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_clamp_zero: assert property (tk && core_raw_diff[10] && !bp |=> res == 16'h0000)
    else $error("clamp");
  a_sign_bit: assert property (tk |=> result_sign_bit == $past(bp && core_raw_diff[10]))
    else $error("sign");
  a_flag_set: assert property (tk |=> conversion_done_flag) else $error("set");
  a_flag_clear: assert property (ok && done_flag_clear |=> !conversion_done_flag)
    else $error("clear");
  a_flag_hold: assert property (ok && !done_flag_clear |=> $stable(conversion_done_flag))
    else $error("hold");
  a_bytes_hold: assert property (ok && $past(ok) && $stable(left_adjust_select)
    |=> $stable(res)) else $error("keep");
  a_temp_enable: assert property (clk_en |=> temp_sensor_enable == $past(tmp))
    else $error("en");
  a_temp_route: assert property (clk_en |=> temp_sensor_channel == $past(tmp))
    else $error("ch");
  cover property (tk && bp && core_raw_diff[10]);
  cover property (tk && left_adjust_select);
  cover property (tmp);
endmodule : arf_result_formatter_sva

// >>> dv/arf_result_formatter_test.sv
// Bench for the result formatter
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module arf_result_formatter_test;
  import arf_pkg::*;
  logic core_clk, rst_n, clk_en, bipolar_select, left_adjust_select, channel_is_diff, start;
  logic done_flag_clear, core_done, conversion_done_flag, result_sign_bit;
  logic temp_sensor_enable, temp_sensor_channel;
  logic [3:0] channel_select;
  logic [10:0] core_raw_diff, sample;
  logic [7:0] result_low_byte, result_high_byte;
  int miscompares, n_checks;
  wire [18:0] seen = {result_high_byte, result_low_byte, result_sign_bit,
                      conversion_done_flag, temp_sensor_enable};
  // Raw, diff/bipolar/adjust, then expected bytes and sign
  // A negative unipolar row, clamped to zero, comes before the two negative bipolar rows, which end the table
  localparam logic [30:0] ROWS [5] = '{{11'h3ff, 3'h1, 17'h1ff80}, {11'h155, 3'h4, 17'h002aa},
    {11'h600, 3'h4, 17'h0}, {11'h400, 3'h6, 17'h00401}, {11'h7fe, 3'h7, 17'h1ff81}};
  arf_result_formatter dut (.*);
  arf_core_model core (.*);
  task automatic print_verdict;
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #2000 miscompares++;
    print_verdict();
  end
  initial begin
    {rst_n, bipolar_select, left_adjust_select, channel_is_diff, done_flag_clear, start} = '0;
    {clk_en, channel_select, sample} = 16'h8000;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    // Growing idle gaps before each row; the core answers one cycle after start every time
    foreach (ROWS[i]) begin
      repeat (i) @(posedge core_clk);
      @(posedge core_clk) {channel_is_diff, bipolar_select, left_adjust_select} <= ROWS[i][19:17];
      {sample, start} <= {ROWS[i][30:20], 1'b1};
      @(posedge core_clk) start <= 1'b0;
      @(posedge core_clk) #1;
      `CHK("result", ROWS[i][16:0], seen[18:2])
    end
    // Temperature channel selected while clearing the done flag and switching to right adjust, no new conversion
    @(posedge core_clk) {left_adjust_select, done_flag_clear, channel_select} <= 6'h1f;
    @(posedge core_clk) done_flag_clear <= 1'b0;
    @(posedge core_clk) #1;
    `CHK("tail", 19'h01ffd, seen)
    // A completion while the enable is low must leave everything frozen
    @(posedge core_clk) {clk_en, start, sample} <= {1'b0, 1'b1, 11'h055};
    @(posedge core_clk) start <= 1'b0;
    @(posedge core_clk);
    @(posedge core_clk) clk_en <= 1'b1;
    @(posedge core_clk) #1;
    `CHK("frozen", 19'h01ffd, seen)
    print_verdict();
  end
endmodule : arf_result_formatter_test
bind arf_result_formatter arf_result_formatter_sva chk (.*);
